//--- hdl/status_pkg.sv
// Purpose: constants for the processor status control block
// Assumes: status word reached as special register index 2
// Notes: reserved status bits read as zero
package status_pkg;
    localparam logic [7:0] PSW_INDEX = 8'h02;
    localparam int TIMER_IRQ_OFF_BIT = 17;
    localparam int IRQ_WAITING_BIT = 14;
    localparam int SINGLE_STEP_ARM_BIT = 13;
    localparam int SINGLE_STEP_DUE_BIT = 12;
    localparam int MISALIGN_CHECK_BIT = 11;
    localparam int STATE_HOLD_BIT = 10;
    localparam int IDLE_WAIT_BIT = 7;
    localparam int PRIVILEGED_BIT = 4;
    localparam int PRIORITY_MASK_LSB = 2;
    localparam int MASK_EXTERNAL_BIT = 1;
    localparam int MASK_ALL_BIT = 0;
    // writable bits: 17, 14..10, 7, 4..0
    localparam logic [31:0] PSW_WRITE_MASK = 32'h00027C9F;
    // reset: privileged, all masked
    localparam logic [31:0] PSW_RESET = 32'h00000013;
    localparam logic [1:0] HOLD_SETTLE_CYCLES = 2'h2;
    typedef enum logic [1:0] {
        ACC_NONE = 2'b00,
        ACC_HALF = 2'b01,
        ACC_WORD = 2'b10,
        ACC_BYTE = 2'b11
    } access_size_t;
    typedef enum logic [1:0] {
        RUN_ST = 2'b00,
        IDLE_ST = 2'b01,
        SETTLE_ST = 2'b10
    } run_state_t;
endpackage : status_pkg

//--- hdl/irq_gate.sv
// Purpose: mask evaluation of interrupt requests
// Assumes: request inputs already synchronous
// Notes: pure combinational gating
`timescale 1ns/1ns
module irq_gate (
    input wire logic [3:0] ext_irq,
    input wire logic periph_irq,
    input wire logic timer_irq,
    input wire logic timer_irq_allow,
    input wire logic timer_irq_off,
    input wire logic mask_all,
    input wire logic mask_external,
    input wire logic [1:0] priority_mask,
    output logic [3:0] ext_ok,
    output logic periph_ok,
    output logic timer_ok,
    output logic any_req,
    output logic any_ok
);
    logic [3:0] line_en;
    always_comb begin
        // line 0 is never masked by priority
        case (priority_mask)
            2'b00: line_en = 4'h1;
            2'b01: line_en = 4'h3;
            2'b10: line_en = 4'h7;
            default: line_en = 4'hF;
        endcase
        ext_ok = ext_irq & line_en
            & {4{~mask_external & ~mask_all}};
        periph_ok = periph_irq & (priority_mask == 2'b11)
            & ~mask_external & ~mask_all;
        timer_ok = timer_irq & timer_irq_allow & ~timer_irq_off
            & ~mask_all;
        any_req = (|ext_irq) | periph_irq
            | (timer_irq & timer_irq_allow & ~timer_irq_off);
        any_ok = (|ext_ok) | periph_ok | timer_ok;
    end
endmodule : irq_gate

//--- hdl/processor_status_control.sv
// Purpose: processor status word and exception gating
// Assumes: pipeline reports completion, accesses and requests per cycle
// Notes: take_event is high toward trap dispatch in every cycle an event is taken
//
// Contract
// - timer off bit suppresses timer interrupt
// - mask all blocks timer interrupt
// - waiting bit set when request masked
// - waiting bit clears when requests vanish
// - copy arm into due at completion
// - due bit raises trace trap
// - misaligned external accesses trap when checking
// - no alignment checking when check off
// - never check io or fetch addresses
// - vector fetch addresses always aligned
// - state hold freezes listed registers
// - taking event sets state hold
// - two cycles settle after hold clears
// - setting state hold acts at once
// - idle wait performs no operations
// - taken event or reset leaves idle
// - privileged bit selects supervisor mode
// - user access to protected context traps
// - occurring events taken only when permitted
// - mask external blocks external and peripheral
// - mask all blocks all but warning
// - priority mask enables lines cumulatively
`timescale 1ns/1ns
module processor_status_control (
    input wire logic clk,
    input wire logic resetn,
    // special register port
    input wire logic [7:0] sr_index,
    input wire logic sr_write,
    input wire logic sr_read,
    input wire logic sr_protected,
    input wire logic [31:0] sr_wdata,
    output logic [31:0] sr_rdata,
    // pipeline events
    input wire logic instr_done,
    input wire logic data_access,
    input wire logic io_access,
    input wire status_pkg::access_size_t access_size,
    input wire logic [1:0] data_addr_low,
    input wire logic sync_trap,
    input wire logic warn_trap,
    // interrupt requests
    input wire logic [3:0] ext_irq,
    input wire logic periph_irq,
    input wire logic timer_irq,
    input wire logic timer_irq_allow,
    // dispatch side
    output logic take_event,
    output logic trace_trap,
    output logic misalign_trap,
    output logic protect_trap,
    output logic hold_regs,
    output logic run_enable,
    output logic supervisor,
    output logic vector_align_low,
    output logic events_ready
);
    import status_pkg::*;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [31:0] psw;
        run_state_t st;
        logic [1:0] settle;
        logic [31:0] rdata;
    } state_t;

    state_t cur_r;
    state_t cur_nxt;

    logic [3:0] ext_ok;
    logic periph_ok;
    logic timer_ok;
    logic any_req;
    logic any_ok;
    logic psw_hit;
    logic [31:0] wr_val;
    logic trap_occurs;
    logic irq_masked;

    function automatic logic misaligned(input access_size_t sz,
                                        input logic [1:0] a);
        case (sz)
            ACC_WORD: misaligned = |a;
            ACC_HALF: misaligned = a[0];
            default: misaligned = 1'b0;
        endcase
    endfunction : misaligned

    irq_gate u_gate (
        .ext_irq(ext_irq),
        .periph_irq(periph_irq),
        .timer_irq(timer_irq),
        .timer_irq_allow(timer_irq_allow),
        .timer_irq_off(cur_r.psw[TIMER_IRQ_OFF_BIT]),
        .mask_all(cur_r.psw[MASK_ALL_BIT]),
        .mask_external(cur_r.psw[MASK_EXTERNAL_BIT]),
        .priority_mask(cur_r.psw[PRIORITY_MASK_LSB +: 2]),
        .ext_ok(ext_ok),
        .periph_ok(periph_ok),
        .timer_ok(timer_ok),
        .any_req(any_req),
        .any_ok(any_ok)
    );

    // ------------------------------------------------------------
    // trap sources
    // ------------------------------------------------------------
    always_comb begin
        psw_hit = sr_index == PSW_INDEX;
        supervisor = cur_r.psw[PRIVILEGED_BIT];
        protect_trap = (sr_write | sr_read) & sr_protected
            & ~cur_r.psw[PRIVILEGED_BIT];
        // io and fetch never checked; only data accesses seen here
        misalign_trap = cur_r.psw[MISALIGN_CHECK_BIT] & data_access
            & ~io_access
            & misaligned(access_size, data_addr_low);
        trace_trap = cur_r.psw[SINGLE_STEP_DUE_BIT];
        trap_occurs = protect_trap | misalign_trap | trace_trap
            | sync_trap;
        // per request, so a masked line counts beside an enabled one
        irq_masked = (|(ext_irq & ~ext_ok)) | (periph_irq & ~periph_ok)
            | (timer_irq & timer_irq_allow
               & ~cur_r.psw[TIMER_IRQ_OFF_BIT] & ~timer_ok);
        // no handler but the warning one may be entered until held state settles
        events_ready = cur_r.st != SETTLE_ST;
        take_event = warn_trap
            | (events_ready & ~cur_r.psw[MASK_ALL_BIT]
               & (trap_occurs | any_ok));
        hold_regs = cur_r.psw[STATE_HOLD_BIT] | take_event;
        run_enable = ~cur_r.psw[IDLE_WAIT_BIT];
        vector_align_low = 1'b0;
        sr_rdata = cur_r.rdata;
    end

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        cur_nxt = cur_r;
        wr_val = (sr_wdata & PSW_WRITE_MASK)
            | (cur_r.psw & ~PSW_WRITE_MASK);
        if (sr_write && psw_hit && !protect_trap)
            cur_nxt.psw = wr_val & PSW_WRITE_MASK;
        if (instr_done && run_enable)
            cur_nxt.psw[SINGLE_STEP_DUE_BIT] =
                cur_nxt.psw[SINGLE_STEP_ARM_BIT];
        if (irq_masked)
            cur_nxt.psw[IRQ_WAITING_BIT] = 1'b1;
        else if (!any_req)
            cur_nxt.psw[IRQ_WAITING_BIT] = 1'b0;
        if (take_event) begin
            cur_nxt.psw[STATE_HOLD_BIT] = 1'b1;
            cur_nxt.psw[IDLE_WAIT_BIT] = 1'b0;
        end
        case (cur_r.st)
            RUN_ST: begin
                if (cur_nxt.psw[IDLE_WAIT_BIT])
                    cur_nxt.st = IDLE_ST;
            end
            IDLE_ST: begin
                if (!cur_nxt.psw[IDLE_WAIT_BIT])
                    cur_nxt.st = RUN_ST;
            end
            SETTLE_ST: begin
                cur_nxt.settle = cur_r.settle - 2'h1;
                if (cur_r.settle == 2'h1)
                    cur_nxt.st = RUN_ST;
            end
            default: cur_nxt.st = RUN_ST;
        endcase
        // any clear restarts the gap, even one inside a running gap
        if (cur_r.psw[STATE_HOLD_BIT]
            && !cur_nxt.psw[STATE_HOLD_BIT]) begin
            cur_nxt.st = SETTLE_ST;
            cur_nxt.settle = HOLD_SETTLE_CYCLES;
        end
        if (sr_read && psw_hit && !protect_trap)
            cur_nxt.rdata = cur_r.psw & PSW_WRITE_MASK;
        else if (sr_read)
            cur_nxt.rdata = 32'h00000000;
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            cur_r.psw <= PSW_RESET;
            cur_r.st <= RUN_ST;
            cur_r.settle <= 2'h0;
            cur_r.rdata <= 32'h00000000;
        end else begin
            cur_r <= cur_nxt;
        end
    end
endmodule : processor_status_control

//--- bench/pipe_model.sv
// Purpose: pipeline stand-in completing instructions
// Assumes: at most one completion per cycle
// Notes: slow halves the completion rate
`timescale 1ns/1ns
module pipe_model (
    input wire logic clk,
    input wire logic resetn,
    input wire logic run_enable,
    input wire logic slow,
    output logic instr_done
);
    logic ph_r;
    always_ff @(posedge clk) ph_r <= resetn & ~ph_r;
    // nothing completes while idle
    assign instr_done = run_enable & resetn & (~slow | ph_r);
endmodule : pipe_model

//--- bench/psc_asserts.sv
// Purpose: port checks for status control
// Assumes: only the status word is read
// Notes: bound after the module
`timescale 1ns/1ns
module psc_asserts
    import status_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic sr_write,
    input wire logic sr_read,
    input wire logic sr_protected,
    input wire logic [31:0] sr_rdata,
    input wire logic instr_done,
    input wire logic data_access,
    input wire logic io_access,
    input wire status_pkg::access_size_t access_size,
    input wire logic [1:0] data_addr_low,
    input wire logic take_event,
    input wire logic trace_trap,
    input wire logic misalign_trap,
    input wire logic protect_trap,
    input wire logic hold_regs,
    input wire logic run_enable,
    input wire logic supervisor,
    input wire logic events_ready
);
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    reserved_zero_a: assert property (
        sr_read |=> (sr_rdata & ~PSW_WRITE_MASK) == 32'h0)
        else $error("reserved bits set");
    trace_cause_a: assert property (
        $rose(trace_trap) |-> $past(instr_done) || $past(sr_write))
        else $error("trace without cause");
    misalign_cause_a: assert property (
        misalign_trap |-> data_access && !io_access
        && (access_size == ACC_WORD && data_addr_low != 2'h0
        || access_size == ACC_HALF && data_addr_low[0]))
        else $error("bad misalign trap");
    hold_on_take_a: assert property (
        take_event |=> hold_regs) else $error("hold not set");
    settle_gap_a: assert property (
        $fell(hold_regs) |=> !events_ready) else $error("no settle gap");
    idle_exit_a: assert property (
        take_event |=> run_enable) else $error("idle kept");
    protect_trap_a: assert property (
        sr_read && sr_protected && !supervisor |-> protect_trap)
        else $error("no protect trap");
    user_only_a: assert property (
        supervisor |-> !protect_trap) else $error("supervisor trapped");
    cover property (take_event);
    cover property ($fell(hold_regs));
    cover property (misalign_trap);
endmodule : psc_asserts
bind processor_status_control psc_asserts psc_asserts_inst (
    .clk(clk), .resetn(resetn), .sr_write(sr_write), .sr_read(sr_read),
    .sr_protected(sr_protected), .sr_rdata(sr_rdata),
    .instr_done(instr_done), .data_access(data_access),
    .io_access(io_access), .access_size(access_size),
    .data_addr_low(data_addr_low), .take_event(take_event),
    .trace_trap(trace_trap), .misalign_trap(misalign_trap),
    .protect_trap(protect_trap), .hold_regs(hold_regs),
    .run_enable(run_enable), .supervisor(supervisor),
    .events_ready(events_ready));

//--- bench/processor_status_control_bench.sv
// Purpose: self-checking bench for status control
// Assumes: clk 40 ns
// Notes: reads are scored from a queue
`timescale 1ns/1ns
module processor_status_control_bench;
    import status_pkg::*;
    logic clk = 1'b0, resetn = 1'b0, slow = 1'b0, sr_write = 1'b0;
    logic sr_read = 1'b0, prot = 1'b0, dacc = 1'b0, io = 1'b0;
    logic warn = 1'b0, tmr = 1'b0, allow = 1'b0, p1 = 1'b0, e, per = 1'b0;
    logic [3:0] ext = 4'h0;
    logic [1:0] low = 2'h0;
    access_size_t size = ACC_NONE;
    logic [31:0] wd = 32'h0, d, r, rdata, q[$];
    logic done, trace, mis, run, take, ptrap, hold, sup, valign, ready;
    int seed = 32'h077D1BB6, err_count = 0, compares = 0, cyc = 0, i;
    always #20 clk = ~clk;
    pipe_model pipe_model_inst (.clk(clk), .resetn(resetn),
        .run_enable(run), .slow(slow), .instr_done(done));
    processor_status_control processor_status_control_inst (
        .clk(clk), .resetn(resetn), .sr_index(PSW_INDEX),
        .sr_write(sr_write), .sr_read(sr_read), .sr_protected(prot),
        .sr_wdata(wd), .sr_rdata(rdata), .instr_done(done),
        .data_access(dacc), .io_access(io), .access_size(size),
        .data_addr_low(low), .sync_trap(1'b0), .warn_trap(warn),
        .ext_irq(ext), .periph_irq(per), .timer_irq(tmr),
        .timer_irq_allow(allow), .take_event(take), .trace_trap(trace),
        .misalign_trap(mis), .protect_trap(ptrap), .hold_regs(hold),
        .run_enable(run), .supervisor(sup), .vector_align_low(valign),
        .events_ready(ready));
    task automatic check(input logic [31:0] s, input logic [31:0] x);
        compares++;
        if (s !== x) begin
            err_count++;
            $display("[FAIL] %0t seen %h expected %h", $time, s, x);
        end
    endtask : check
    task automatic finish_test();
        $display("compares %0d errors %0d", compares, err_count);
        if (err_count == 0 && compares > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : finish_test
    task automatic wr(input logic [31:0] v);
        sr_write <= 1'b1;
        wd <= v;
        @(posedge clk);
        sr_write <= 1'b0;
        @(posedge clk);
    endtask : wr
    task automatic rd(input logic [31:0] x);
        q.push_back(x);
        sr_read <= 1'b1;
        @(posedge clk);
        sr_read <= 1'b0;
        @(posedge clk);
    endtask : rd
    task automatic pend(input logic [31:0] w, input logic [5:0] m,
                        input logic [31:0] x);
        wr(w);
        {ext, tmr, allow} <= m;
        @(posedge clk);
        rd(x);
    endtask : pend
    always @(posedge clk) begin
        if (p1) check(rdata, q.pop_front());
        p1 <= sr_read;
        cyc++;
        if (cyc > 2000) begin
            err_count++;
            finish_test();
        end
    end
    initial begin
        repeat (3) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        rd(32'h13);
        check(valign, 1'b0);
        check(sup, 1'b1);
        for (i = 0; i < 4; i++) begin
            d = $random(seed) & 32'hFFFF8F7F | 32'h11;
            wr(d);
            rd(d & PSW_WRITE_MASK);
        end
        pend(32'h10, 6'h08, 32'h4010);
        pend(32'h13, 6'h04, 32'h4013);
        pend(32'h13, 6'h00, 32'h13);
        pend(32'h13, 6'h03, 32'h4013);
        pend(32'h20013, 6'h03, 32'h20013);
        {ext, tmr, allow, slow} <= 7'h01;
        per <= 1'b1;
        wr(32'h1E);
        rd(32'h401E);
        per <= 1'b0;
        for (i = 0; i < 32; i++) begin
            if (i % 16 == 0) wr(i < 16 ? 32'h813 : 32'h13);
            r = $random(seed);
            size <= access_size_t'(i[3:2]);
            low <= i[1:0];
            io <= r[0];
            dacc <= 1'b1;
            @(posedge clk);
            e = i < 16 && !r[0] && (i[3:2] == ACC_WORD && i[1:0] != 0
                || i[3:2] == ACC_HALF && i[0]);
            check(mis, e);
        end
        {dacc, slow} <= 2'h0;
        wr(32'h2013);
        check(take, 1'b0);
        rd(32'h3013);
        check(trace, 1'b1);
        wr(32'h3012);
        check(take, 1'b1);
        check(hold, 1'b1);
        rd(32'h3412);
        // the trace taken in the write cycle keeps hold set
        wr(32'h13);
        rd(32'h413);
        wr(32'h13);
        check(ready, 1'b0);
        check(hold, 1'b0);
        rd(32'h13);
        check(ready, 1'b1);
        wr(32'h93);
        check(run, 1'b0);
        warn <= 1'b1;
        @(posedge clk);
        warn <= 1'b0;
        rd(32'h413);
        check(run, 1'b1);
        check(hold, 1'b1);
        wr(32'h01);
        check(sup, 1'b0);
        prot <= 1'b1;
        rd(32'h0);
        sr_write <= 1'b1;
        wd <= 32'h13;
        @(posedge clk);
        check(ptrap, 1'b1);
        sr_write <= 1'b0;
        prot <= 1'b0;
        rd(32'h1);
        @(posedge clk);
        finish_test();
    end
endmodule : processor_status_control_bench
